//--- hdl/mtap_defs.svh
`ifndef MTAP_DEFS_SVH
`define MTAP_DEFS_SVH
// least low time on the trigger pin, in ns, and in cycles at 100 MHz
`define MTAP_TRIG_LOW_NS 4000
`define MTAP_CLK_NS 10
`define MTAP_TRIG_LOW_CYC ((`MTAP_TRIG_LOW_NS + `MTAP_CLK_NS - 1) / `MTAP_CLK_NS)
// reset values of the pin controls
`define MTAP_RST_GPIO_OUT_EN 1'b0
`define MTAP_RST_ENABLE 1'b0
`define MTAP_RST_LATCH 1'b0
// width of the warning delay and critical filter counts
`define MTAP_DLY_W 8
// slave address: fixed prefix above the two pin codes, and its reset value
`define MTAP_ADDR_PREFIX 3'h4
`define MTAP_RST_SLAVE_ADDR 7'h40
`endif

//--- hdl/mtap_pkg.sv
package mtap_pkg;
  typedef enum logic [1:0] {
    MTAP_IDLE = 2'b00,
    MTAP_LOW = 2'b01,
    MTAP_DONE = 2'b11
  } mtap_trig_t;
endpackage

//--- hdl/mtap_top.sv
// Behaviour
// RULE1: trigger falling edge starts conversion in triggered mode
// RULE2: controller holds trigger low at least 4 us
// RULE3: trigger held low: each mode write starts conversion
// RULE4: gpio input or push-pull output, input after reset
// RULE5: critical open-drain low, filtered, reset disabled unlatched
// RULE6: over-limit open-drain low, reset disabled transparent
// RULE7: warning open-drain low, delayed, reset disabled unlatched
// RULE8: alert open-drain, masked, disabled after reset
// RULE9: address pins sampled at each bus transaction start
// RULE10: open-drain pulls low only when asserted and enabled
`timescale 1ns/1ps
`default_nettype none
`include "mtap_defs.svh"
module mtap_top
  import mtap_pkg::*;
#(
  parameter int DLY_W = `MTAP_DLY_W
) (
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic TRIGGERED_MODE_I,
  input wire logic MODE_WRITE_I,
  input wire logic CONV_TRIG_N_I,
  output logic CONV_START_O,
  output logic TRIG_LOW_SHORT_O,
  input wire logic GPIO_OUT_EN_I,
  input wire logic GPIO_OUT_VAL_I,
  input wire logic GPIO_PIN_I,
  output logic GPIO_PIN_O,
  output logic GPIO_PIN_OE_O,
  output logic GPIO_IN_VAL_O,
  input wire logic CRIT_EN_I,
  input wire logic CRIT_LATCH_I,
  input wire logic [DLY_W-1:0] CRIT_FILT_I,
  input wire logic CRIT_COND_I,
  input wire logic OVER_EN_I,
  input wire logic OVER_LATCH_I,
  input wire logic OVER_COND_I,
  input wire logic WARN_EN_I,
  input wire logic WARN_LATCH_I,
  input wire logic [DLY_W-1:0] WARN_DLY_I,
  input wire logic WARN_COND_I,
  input wire logic FLAG_CLR_I,
  input wire logic [2:0] ALERT_MASK_I,
  output logic CRIT_O,
  output logic CRIT_OE_O,
  output logic OVER_O,
  output logic OVER_OE_O,
  output logic WARN_O,
  output logic WARN_OE_O,
  output logic ALERT_O,
  output logic ALERT_OE_O,
  input wire logic BUS_START_I,
  input wire logic [1:0] ADDR_SEL_LOW_I,
  input wire logic [1:0] ADDR_SEL_HIGH_I,
  output logic [6:0] SLAVE_ADDR_O
);
  localparam int LOW_CYC = `MTAP_TRIG_LOW_CYC;

  typedef struct packed {
    mtap_trig_t trig;
    logic [15:0] low_cnt;
    logic conv;
    logic short_low;
    logic gpio_oe;
    logic gpio_o;
    logic gpio_in;
    logic [DLY_W-1:0] crit_cnt;
    logic [DLY_W-1:0] warn_cnt;
    logic crit_flag;
    logic over_flag;
    logic warn_flag;
    logic crit_oe;
    logic over_oe;
    logic warn_oe;
    logic alert_oe;
    logic [6:0] addr;
  } mtap_state_t;

  mtap_state_t st_r;
  mtap_state_t st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic crit_act;
    logic warn_act;
    crit_act = 1'b0;
    warn_act = 1'b0;
    st_nxt = st_r;
    st_nxt.conv = 1'b0;
    // trigger pin watcher; edge found against last sample
    unique case (st_r.trig)
      MTAP_IDLE: begin
        if (!CONV_TRIG_N_I) begin
          st_nxt.trig = MTAP_LOW;
          st_nxt.low_cnt = 16'h1;
          st_nxt.conv = TRIGGERED_MODE_I; // [RULE1]
        end
      end
      MTAP_LOW: begin
        if (CONV_TRIG_N_I) begin
          st_nxt.trig = MTAP_IDLE;
          // too-short pulse is flagged, conversion still stands
          st_nxt.short_low = (32'(st_r.low_cnt) < LOW_CYC); // [RULE2]
        end else if (32'(st_r.low_cnt) >= LOW_CYC) begin
          st_nxt.trig = MTAP_DONE;
        end else begin
          st_nxt.low_cnt = st_r.low_cnt + 16'h1;
        end
      end
      MTAP_DONE: begin
        if (CONV_TRIG_N_I) begin
          st_nxt.trig = MTAP_IDLE;
          st_nxt.short_low = 1'b0;
        end
      end
      // unused code 2'b10: fall back to idle rather than lock up
      default: begin
        st_nxt.trig = MTAP_IDLE;
      end
    endcase
    // pin held low in triggered mode: every mode write fires a conversion
    if (st_r.trig != MTAP_IDLE && !CONV_TRIG_N_I && TRIGGERED_MODE_I && MODE_WRITE_I) begin
      st_nxt.conv = 1'b1; // [RULE3]
    end
    // gpio direction and capture
    st_nxt.gpio_oe = GPIO_OUT_EN_I; // [RULE4]
    st_nxt.gpio_o = GPIO_OUT_VAL_I;
    st_nxt.gpio_in = GPIO_PIN_I;
    // critical filter: condition must hold for the filter count
    if (!CRIT_COND_I) begin
      st_nxt.crit_cnt = '0;
    end else if (st_r.crit_cnt < CRIT_FILT_I) begin
      st_nxt.crit_cnt = st_r.crit_cnt + DLY_W'(1);
    end
    crit_act = CRIT_COND_I && (st_r.crit_cnt >= CRIT_FILT_I); // [RULE5]
    // warning delay counter
    if (!WARN_COND_I) begin
      st_nxt.warn_cnt = '0;
    end else if (st_r.warn_cnt < WARN_DLY_I) begin
      st_nxt.warn_cnt = st_r.warn_cnt + DLY_W'(1);
    end
    warn_act = WARN_COND_I && (st_r.warn_cnt >= WARN_DLY_I); // [RULE7]
    // latched flags: a set in the clear cycle wins
    st_nxt.crit_flag = crit_act || (CRIT_LATCH_I && st_r.crit_flag && !FLAG_CLR_I);
    st_nxt.over_flag = OVER_COND_I || (OVER_LATCH_I && st_r.over_flag && !FLAG_CLR_I); // [RULE6]
    st_nxt.warn_flag = warn_act || (WARN_LATCH_I && st_r.warn_flag && !FLAG_CLR_I);
    // drive low only when flagged and enabled
    st_nxt.crit_oe = st_nxt.crit_flag && CRIT_EN_I; // [RULE10]
    st_nxt.over_oe = st_nxt.over_flag && OVER_EN_I;
    st_nxt.warn_oe = st_nxt.warn_flag && WARN_EN_I;
    st_nxt.alert_oe = |(ALERT_MASK_I & {st_nxt.crit_flag, st_nxt.over_flag, st_nxt.warn_flag}); // [RULE8]
    // slave address caught at each transaction start
    if (BUS_START_I) begin
      st_nxt.addr = {`MTAP_ADDR_PREFIX, ADDR_SEL_HIGH_I, ADDR_SEL_LOW_I}; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.addr <= `MTAP_RST_SLAVE_ADDR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign CONV_START_O = st_r.conv;
  assign TRIG_LOW_SHORT_O = st_r.short_low;
  assign GPIO_PIN_O = st_r.gpio_o;
  assign GPIO_PIN_OE_O = st_r.gpio_oe;
  assign GPIO_IN_VAL_O = st_r.gpio_in;
  assign CRIT_O = 1'b0; // open-drain: only ever drives low
  assign OVER_O = 1'b0;
  assign WARN_O = 1'b0;
  assign ALERT_O = 1'b0;
  assign CRIT_OE_O = st_r.crit_oe;
  assign OVER_OE_O = st_r.over_oe;
  assign WARN_OE_O = st_r.warn_oe;
  assign ALERT_OE_O = st_r.alert_oe;
  assign SLAVE_ADDR_O = st_r.addr;

  ////////////////////////////////////////////////////////////////////////
  // checks
  trig_start_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE1]
    (st_r.trig == MTAP_IDLE && !CONV_TRIG_N_I && TRIGGERED_MODE_I) |=> CONV_START_O)
    else $error("falling trigger gave no conversion");
  held_write_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE3]
    (st_r.trig != MTAP_IDLE && !CONV_TRIG_N_I && TRIGGERED_MODE_I && MODE_WRITE_I) |=> CONV_START_O)
    else $error("mode write while held low gave no conversion");
  no_conv_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE1]
    !TRIGGERED_MODE_I |=> !CONV_START_O)
    else $error("conversion outside triggered mode");
  gpio_dir_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE4]
    !GPIO_OUT_EN_I |=> !GPIO_PIN_OE_O)
    else $error("gpio driven while input");
  crit_filt_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE5]
    (CRIT_EN_I && !CRIT_LATCH_I && !CRIT_COND_I) |=> !CRIT_OE_O)
    else $error("critical pulled without condition");
  over_fast_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE6]
    (OVER_EN_I && OVER_COND_I) |=> OVER_OE_O)
    else $error("over-limit not pulled");
  warn_dly_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE7]
    (WARN_EN_I && !WARN_LATCH_I && WARN_COND_I && $rose(WARN_COND_I) && WARN_DLY_I != '0) |=> !WARN_OE_O)
    else $error("warning not delayed");
  alert_mask_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE8]
    (ALERT_MASK_I == 3'h0) |=> !ALERT_OE_O)
    else $error("alert pulled while masked");
  addr_samp_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE9]
    BUS_START_I |=> (SLAVE_ADDR_O[3:0] == {$past(ADDR_SEL_HIGH_I), $past(ADDR_SEL_LOW_I)}))
    else $error("address not sampled");
  od_release_a: assert property (@(posedge REF_CLK_I) disable iff (!rst_n) // [RULE10]
    !WARN_EN_I |=> !WARN_OE_O)
    else $error("warning pulled while disabled");
endmodule
`default_nettype wire

//--- tb/mtap_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller side: kicks the trigger, watches the open-drain lines
module mtap_ctrl_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [9:0] low_i,
  input wire logic [3:0] oe_i,
  output logic trig_n_o,
  output logic [3:0] line_o
);
  // starts idle so the trigger rests high through reset
  logic [9:0] cnt_r = 10'h0;
  // low time chosen per kick, so short pulses can be forced
  always_ff @(posedge clk_i) begin
    if (go_i) cnt_r <= low_i;
    else if (cnt_r != 10'h0) cnt_r <= cnt_r - 10'h1;
  end
  assign trig_n_o = (cnt_r == 10'h0);
  // pull-ups: a released line reads high
  assign line_o = ~oe_i;
endmodule
`default_nettype wire

//--- tb/monitor_trigger_and_alert_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value at %0t: got %0h want %0h", $time, (g), (e)); \
  end \
end
module monitor_trigger_and_alert_pins_tb;
  logic REF_CLK_I, ARST_N_I, TRIGGERED_MODE_I, MODE_WRITE_I, CONV_TRIG_N_I, CONV_START_O, TRIG_LOW_SHORT_O;
  logic GPIO_OUT_EN_I, GPIO_OUT_VAL_I, GPIO_PIN_I, GPIO_PIN_O, GPIO_PIN_OE_O, GPIO_IN_VAL_O, gpio_ext;
  logic CRIT_EN_I, CRIT_LATCH_I, CRIT_COND_I, OVER_EN_I, OVER_LATCH_I, OVER_COND_I, FLAG_CLR_I, BUS_START_I;
  logic WARN_EN_I, WARN_LATCH_I, WARN_COND_I, CRIT_O, CRIT_OE_O, OVER_O, OVER_OE_O, WARN_O, WARN_OE_O;
  logic ALERT_O, ALERT_OE_O, go;
  logic [7:0] CRIT_FILT_I, WARN_DLY_I;
  logic [2:0] ALERT_MASK_I;
  logic [1:0] ADDR_SEL_LOW_I, ADDR_SEL_HIGH_I;
  logic [6:0] SLAVE_ADDR_O;
  logic [9:0] low;
  logic [3:0] line;
  int fail_count, checks, p, n, cyc;
  mtap_top dut (
    .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .TRIGGERED_MODE_I(TRIGGERED_MODE_I),
    .MODE_WRITE_I(MODE_WRITE_I), .CONV_TRIG_N_I(CONV_TRIG_N_I), .CONV_START_O(CONV_START_O),
    .TRIG_LOW_SHORT_O(TRIG_LOW_SHORT_O), .GPIO_OUT_EN_I(GPIO_OUT_EN_I), .GPIO_OUT_VAL_I(GPIO_OUT_VAL_I),
    .GPIO_PIN_I(GPIO_PIN_I), .GPIO_PIN_O(GPIO_PIN_O), .GPIO_PIN_OE_O(GPIO_PIN_OE_O),
    .GPIO_IN_VAL_O(GPIO_IN_VAL_O), .CRIT_EN_I(CRIT_EN_I), .CRIT_LATCH_I(CRIT_LATCH_I),
    .CRIT_FILT_I(CRIT_FILT_I), .CRIT_COND_I(CRIT_COND_I), .OVER_EN_I(OVER_EN_I),
    .OVER_LATCH_I(OVER_LATCH_I), .OVER_COND_I(OVER_COND_I), .WARN_EN_I(WARN_EN_I),
    .WARN_LATCH_I(WARN_LATCH_I), .WARN_DLY_I(WARN_DLY_I), .WARN_COND_I(WARN_COND_I),
    .FLAG_CLR_I(FLAG_CLR_I), .ALERT_MASK_I(ALERT_MASK_I), .CRIT_O(CRIT_O), .CRIT_OE_O(CRIT_OE_O),
    .OVER_O(OVER_O), .OVER_OE_O(OVER_OE_O), .WARN_O(WARN_O), .WARN_OE_O(WARN_OE_O),
    .ALERT_O(ALERT_O), .ALERT_OE_O(ALERT_OE_O), .BUS_START_I(BUS_START_I),
    .ADDR_SEL_LOW_I(ADDR_SEL_LOW_I), .ADDR_SEL_HIGH_I(ADDR_SEL_HIGH_I), .SLAVE_ADDR_O(SLAVE_ADDR_O)
  );
  mtap_ctrl_model ctrl (.clk_i(REF_CLK_I), .go_i(go), .low_i(low), .oe_i({ALERT_OE_O, CRIT_OE_O, OVER_OE_O, WARN_OE_O}),
    .trig_n_o(CONV_TRIG_N_I), .line_o(line));
  // the gpio wire: our drive wins only while the pin is an input
  assign GPIO_PIN_I = GPIO_PIN_OE_O ? GPIO_PIN_O : gpio_ext;
  initial begin
    REF_CLK_I = 1'b0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end
  // hang guard, well above the roughly 1200 cycles needed
  always @(posedge REF_CLK_I) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test;
    end
  end
  task step(input int k);
    repeat (k) @(negedge REF_CLK_I);
  endtask
  // one trigger kick and/or mode write; counts start pulses after it
  task kick(input logic g, input logic w, input logic [9:0] l);
    go = g;
    MODE_WRITE_I = w;
    low = l;
    p = 0;
    // strobes drop once only, so a following call may raise them cleanly
    @(negedge REF_CLK_I);
    go = 1'b0;
    MODE_WRITE_I = 1'b0;
    if (CONV_START_O === 1'b1) p++;
    repeat (4) begin
      @(negedge REF_CLK_I);
      if (CONV_START_O === 1'b1) p++;
    end
  endtask
  // cycles from raising one condition until its pin pulls low
  task dly(input int s);
    {CRIT_COND_I, OVER_COND_I, WARN_COND_I} = 3'h0;
    step(4);
    {CRIT_COND_I, OVER_COND_I, WARN_COND_I} = 3'h1 << s;
    n = 0;
    while ({CRIT_OE_O, OVER_OE_O, WARN_OE_O} !== (3'h1 << s) && n < 20) begin
      step(1);
      n++;
    end
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {ARST_N_I, TRIGGERED_MODE_I, MODE_WRITE_I, go, gpio_ext, GPIO_OUT_EN_I, GPIO_OUT_VAL_I, FLAG_CLR_I, BUS_START_I} = 9'h080;
    {CRIT_EN_I, OVER_EN_I, WARN_EN_I, CRIT_LATCH_I, OVER_LATCH_I, WARN_LATCH_I} = 6'h0;
    {CRIT_COND_I, OVER_COND_I, WARN_COND_I} = 3'h7;
    {ADDR_SEL_HIGH_I, ADDR_SEL_LOW_I} = 4'h0;
    {CRIT_FILT_I, WARN_DLY_I, ALERT_MASK_I, low} = {8'h02, 8'h03, 3'h0, 10'h0};
    step(3);
    `CHK(SLAVE_ADDR_O, 7'h40)
    ARST_N_I = 1'b1;
    step(8);
    // faults present but every output disabled: nothing may pull low
    `CHK({GPIO_PIN_OE_O, CRIT_OE_O, OVER_OE_O, WARN_OE_O, ALERT_OE_O}, 5'h0)
    `CHK(line, 4'hf)
    kick(1'b1, 1'b0, 10'h1f4);
    `CHK(p, 1)
    kick(1'b0, 1'b1, 10'h0);
    `CHK(p, 1)
    step(500);
    `CHK(TRIG_LOW_SHORT_O, 1'b0)
    kick(1'b0, 1'b1, 10'h0);
    `CHK(p, 0)
    kick(1'b1, 1'b0, 10'h032);
    `CHK(p, 1)
    step(60);
    `CHK(TRIG_LOW_SHORT_O, 1'b1)
    TRIGGERED_MODE_I = 1'b0;
    kick(1'b1, 1'b0, 10'h1f4);
    `CHK(p, 0)
    step(500);
    `CHK(TRIG_LOW_SHORT_O, 1'b0)
    {GPIO_OUT_EN_I, GPIO_OUT_VAL_I} = 2'h3;
    step(3);
    `CHK({GPIO_PIN_OE_O, GPIO_PIN_O, GPIO_IN_VAL_O}, 3'h7)
    {GPIO_OUT_EN_I, gpio_ext} = 2'h0;
    step(3);
    `CHK({GPIO_PIN_OE_O, GPIO_IN_VAL_O}, 2'h0)
    {CRIT_EN_I, OVER_EN_I, WARN_EN_I} = 3'h7;
    ALERT_MASK_I = 3'h7;
    dly(0);
    `CHK(n, int'(WARN_DLY_I) + 1)
    `CHK(line[3], 1'b0)
    `CHK({CRIT_O, OVER_O, WARN_O, ALERT_O}, 4'h0)
    dly(2);
    `CHK(n, int'(CRIT_FILT_I) + 1)
    ALERT_MASK_I = 3'h5;
    dly(1);
    `CHK(n, 1)
    `CHK(ALERT_OE_O, 1'b0)
    OVER_LATCH_I = 1'b1;
    OVER_COND_I = 1'b0;
    step(4);
    `CHK(OVER_OE_O, 1'b1)
    FLAG_CLR_I = 1'b1;
    step(1);
    FLAG_CLR_I = 1'b0;
    step(3);
    `CHK(line, 4'hf)
    // a fault in the clear cycle must set the flag, which then stays latched
    {OVER_COND_I, FLAG_CLR_I} = 2'h3;
    step(1);
    {OVER_COND_I, FLAG_CLR_I} = 2'h0;
    step(2);
    `CHK(OVER_OE_O, 1'b1)
    for (int i = 0; i < 16; i++) begin
      {ADDR_SEL_HIGH_I, ADDR_SEL_LOW_I} = i[3:0];
      BUS_START_I = 1'b1;
      step(1);
      BUS_START_I = 1'b0;
      step(1);
      `CHK(SLAVE_ADDR_O, {3'h4, i[3:0]})
    end
    end_of_test;
  end
endmodule
`default_nettype wire
